/* File: aipp_map.svh */
`ifndef AIPP_MAP_SVH
`define AIPP_MAP_SVH
`define AIPP_CLK_KHZ 10000
`define AIPP_PERIOD_US 1000
`define AIPP_TICK_CYC (`AIPP_PERIOD_US * `AIPP_CLK_KHZ / 1000)
`define AIPP_AVG_N 4'h8
`define AIPP_AVG_SH 3
`define AIPP_GAIN_ONE 16'h1000
`define AIPP_GAIN_SH 12
`define AIPP_OPEN_CODE 16'h7FFF
`define AIPP_OPEN_LIM 16'hFED4
`define AIPP_UNI_LO 16'hFED4
`define AIPP_UNI_HI 16'h189C
`define AIPP_BIP_LO 16'hF31C
`define AIPP_BIP_HI 16'h0CE4
`define AIPP_BIP_ZERO 16'hF448
`define AIPP_SPAN 16'h1770
`define AIPP_CAL_WIN 16'h012C
`define AIPP_DIV_STEPS 5'h1C
`define AIPP_RNG_0_5V 3'h0
`define AIPP_RNG_1_5V 3'h1
`define AIPP_RNG_0_10V 3'h2
`define AIPP_RNG_B10V 3'h3
`define AIPP_RNG_4_20MA 3'h4
`define AIPP_RNG_0_20MA 3'h5
`define AIPP_SW_AVG 12
`define AIPP_SW_FOUR 13
`define AIPP_SW_SOFT 15
`define AIPP_NV_OFS 2'h0
`define AIPP_NV_GAIN 2'h1
`define AIPP_NV_RANGE 2'h2
`define AIPP_LD_END 5'h19
`define AIPP_BLK_DATA 2'h0
`define AIPP_BLK_RANGE 2'h2
`define AIPP_A_STAT 5'h08
`define AIPP_A_CFG 5'h09
`define AIPP_A_CAL 5'h0A
`define AIPP_CAL_OFS 8
`define AIPP_CAL_GAIN 9
`define AIPP_CFG_AVG 0
`define AIPP_CFG_FOUR 1
`define AIPP_CFG_SOFT 2
`define AIPP_CFG_RUN 3
`define AIPP_CFG_CBUSY 4
`define AIPP_CFG_CERR 5
`endif

/* File: aipp_pkg.sv */
package aipp_pkg;
    typedef enum logic [1:0] {CTL_LOAD, CTL_RUN} aipp_ctl_t;
    typedef enum logic [1:0] {CAL_IDLE, CAL_WAIT, CAL_DIV, CAL_STORE} aipp_cal_t;
    typedef logic signed [15:0] aipp_word_t;
endpackage

/* File: aipp_mem.sv */
`timescale 1ns/1ps
module aipp_mem #(
    parameter int W = 16,
    parameter int AW = 5
) (
    input wire logic clk, // Clock
    input wire logic we, // Write enable
    input wire logic [AW-1:0] waddr, // Write address
    input wire logic [W-1:0] wdata, // Write data
    input wire logic [AW-1:0] raddr, // Read address
    output logic [W-1:0] rdata // Registered read data
);
    logic [W-1:0] mem [2**AW];

    // Blank store reads as zero, which every stored field treats as default
    initial begin
        for (int i = 0; i < 2**AW; i++) begin
            mem[i] = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // aipp_mem

/* File: aipp_core.sv */
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "aipp_map.svh"

// Functional notes
// - Averaging applies to all eight channels together
// - Output is moving average of last eight
// - Refresh stays one millisecond per channel
// - Withhold first averaged value until eight samples
// - One-to-five volt below 0.8 V reports 7FFF
// - Four-to-twenty mA below 3.2 mA reports open
// - Open state re-evaluated at each conversion
// - Open clears itself when input returns
// - Negative results are two's complement words
// - Eight channel mode refreshes every 8 ms
// - Four channel mode converts every 4 ms
// - Software ranges per channel, else switch pairs
// - Written ranges take effect after reset only
// - Offset capture maps input to zero, stored
// - Gain capture maps input to full, stored
// - Offset limited to range dependent window
// - Gain limited to range dependent window
// - Out of range input clamps at limits
// - Bipolar scale F448..0BB8, span F31C..0CE4
// - Four channel mode uses even channels only
module aipp_core #(
    parameter int TICK_CYC = `AIPP_TICK_CYC
) (
    input wire logic MCLK, // System clock, 10 MHz
    input wire logic RST, // Synchronous reset, active high
    input wire logic [15:0] SW, // Setting switch pins
    output logic ADC_START, // Start conversion pulse
    output logic [2:0] ADC_CH, // Channel to convert
    output logic [2:0] ADC_RANGE, // Range of that channel
    input wire logic ADC_DONE, // Raw result valid pulse
    input wire logic [15:0] ADC_RAW, // Raw result, signed
    input wire logic [4:0] REG_ADDR, // Register address
    input wire logic [15:0] REG_WDATA, // Register write data
    input wire logic REG_WR, // Write strobe
    input wire logic REG_RD, // Read strobe
    output logic [15:0] REG_RDATA // Read data, cycle after strobe
);
    localparam aipp_pkg::aipp_word_t UNI_LO = `AIPP_UNI_LO;
    localparam aipp_pkg::aipp_word_t UNI_HI = `AIPP_UNI_HI;
    localparam aipp_pkg::aipp_word_t BIP_LO = `AIPP_BIP_LO;
    localparam aipp_pkg::aipp_word_t BIP_HI = `AIPP_BIP_HI;
    localparam aipp_pkg::aipp_word_t BIP_ZERO = `AIPP_BIP_ZERO;
    localparam aipp_pkg::aipp_word_t OPEN_LIM = `AIPP_OPEN_LIM;
    localparam aipp_pkg::aipp_word_t WIN = `AIPP_CAL_WIN;
    localparam aipp_pkg::aipp_word_t SPAN = `AIPP_SPAN;

    function automatic logic is_live_zero(input logic [2:0] r);
        return r == `AIPP_RNG_1_5V || r == `AIPP_RNG_4_20MA;
    endfunction

    function automatic logic is_bipolar(input logic [2:0] r);
        return r == `AIPP_RNG_B10V;
    endfunction

    // Unlisted codes fall back to the lowest voltage range
    function automatic logic [2:0] valid_range(input logic [2:0] r);
        return r > `AIPP_RNG_0_20MA ? `AIPP_RNG_0_5V : r;
    endfunction

    logic [15:0] sw_s1_reg, sw_s2_reg;
    aipp_pkg::aipp_ctl_t ctl_state_reg;
    aipp_pkg::aipp_cal_t cal_state_reg;
    logic [4:0] ld_cnt_reg;
    logic avg_en_reg, four_reg, soft_reg;
    logic [2:0] range_act_reg [8];
    logic [2:0] range_pend_reg [8];
    aipp_pkg::aipp_word_t ofs_reg [8];
    logic [15:0] gain_reg [8];
    logic [31:0] tick_cnt_reg;
    logic [2:0] conv_ch_reg;
    logic [2:0] ptr_reg [8];
    logic [3:0] cnt_reg [8];
    logic signed [18:0] sum_reg [8];
    logic s1_vld_reg, s1_open_reg;
    logic [2:0] s1_ch_reg;
    aipp_pkg::aipp_word_t s1_val_reg;
    logic [15:0] data_reg [8];
    logic [7:0] open_reg, ready_reg;
    logic [2:0] cal_ch_reg;
    logic cal_gain_reg, cal_err_reg;
    logic [15:0] cal_res_reg;
    logic [45:0] div_acc_reg;
    logic [16:0] div_d_reg;
    logic [4:0] div_cnt_reg;
    logic [15:0] nv_rdata, hist_rdata;

    // Switch pins are asynchronous to the core
    always_ff @(posedge MCLK) begin
        sw_s1_reg <= SW;
        sw_s2_reg <= sw_s1_reg;
    end

    wire logic running = ctl_state_reg == aipp_aipp_run();
    function automatic aipp_pkg::aipp_ctl_t aipp_aipp_run();
        return aipp_pkg::CTL_RUN;
    endfunction

    // Stored word index {kind, channel} walks 0..24 during load
    wire logic [4:0] ld_prev = ld_cnt_reg - 5'h01;
    wire logic ld_store = !running && ld_cnt_reg != 5'h00;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            ctl_state_reg <= aipp_pkg::CTL_LOAD;
            ld_cnt_reg <= 5'h00;
        end else if (!running) begin
            ld_cnt_reg <= ld_cnt_reg + 5'h01;
            if (ld_cnt_reg == `AIPP_LD_END) begin
                ctl_state_reg <= aipp_pkg::CTL_RUN;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            for (int i = 0; i < 8; i++) begin
                ofs_reg[i] <= 16'h0000;
                gain_reg[i] <= `AIPP_GAIN_ONE;
                range_pend_reg[i] <= `AIPP_RNG_0_5V;
            end
        end else if (ld_store) begin
            case (ld_prev[4:3])
                `AIPP_NV_OFS: ofs_reg[ld_prev[2:0]] <= nv_rdata;
                `AIPP_NV_GAIN: gain_reg[ld_prev[2:0]] <=
                    nv_rdata + `AIPP_GAIN_ONE;
                `AIPP_NV_RANGE: range_pend_reg[ld_prev[2:0]] <=
                    nv_rdata[2:0];
                default: ;
            endcase
        end else if (REG_WR && REG_ADDR[4:3] == `AIPP_BLK_RANGE) begin
            range_pend_reg[REG_ADDR[2:0]] <= REG_WDATA[2:0];
        end
    end

    // Settings freeze when load ends; later writes wait for a reset
    always_ff @(posedge MCLK) begin
        if (RST) begin
            avg_en_reg <= 1'b0;
            four_reg <= 1'b0;
            soft_reg <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                range_act_reg[i] <= `AIPP_RNG_0_5V;
            end
        end else if (!running && ld_cnt_reg == `AIPP_LD_END) begin
            avg_en_reg <= sw_s2_reg[`AIPP_SW_AVG];
            four_reg <= sw_s2_reg[`AIPP_SW_FOUR];
            soft_reg <= sw_s2_reg[`AIPP_SW_SOFT];
            for (int i = 0; i < 8; i++) begin
                range_act_reg[i] <= valid_range(sw_s2_reg[`AIPP_SW_SOFT] ?
                    range_pend_reg[i] : sw_s2_reg[(i / 2) * 3 +: 3]);
            end
        end
    end

    // One channel per tick keeps the 1 ms per point cadence
    wire logic tick_wrap = tick_cnt_reg == 32'(TICK_CYC - 1);

    always_ff @(posedge MCLK) begin
        if (RST || !running || tick_wrap) begin
            tick_cnt_reg <= 32'h0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            conv_ch_reg <= 3'h0;
            ADC_START <= 1'b0;
            ADC_CH <= 3'h0;
            ADC_RANGE <= 3'h0;
        end else begin
            ADC_START <= running && tick_wrap;
            if (running && tick_wrap) begin
                ADC_CH <= conv_ch_reg;
                ADC_RANGE <= range_act_reg[conv_ch_reg];
                conv_ch_reg <= conv_ch_reg + (four_reg ? 3'h2 : 3'h1);
            end
        end
    end

    // Correction: ((raw - offset - zero) * gain >> 12) + zero
    wire logic [2:0] cv_rng = range_act_reg[ADC_CH];
    wire logic cv_bip = is_bipolar(cv_rng);
    wire logic signed [17:0] cv_zero = cv_bip ? 18'(BIP_ZERO) : 18'sh0;
    wire logic signed [17:0] cv_diff = 18'($signed(ADC_RAW))
        - 18'(ofs_reg[ADC_CH]) - cv_zero;
    wire logic signed [35:0] cv_prod = 36'(cv_diff)
        * $signed({20'h0, gain_reg[ADC_CH]});
    wire logic signed [35:0] cv_scl = (cv_prod >>> `AIPP_GAIN_SH)
        + 36'(cv_zero);
    wire logic signed [35:0] cv_lo = 36'(cv_bip ? BIP_LO : UNI_LO);
    wire logic signed [35:0] cv_hi = 36'(cv_bip ? BIP_HI : UNI_HI);
    wire logic cv_open = is_live_zero(cv_rng) && cv_scl < 36'(OPEN_LIM);
    wire aipp_pkg::aipp_word_t cv_val = cv_scl < cv_lo ? cv_lo[15:0] :
        cv_scl > cv_hi ? cv_hi[15:0] : cv_scl[15:0];

    always_ff @(posedge MCLK) begin
        if (RST) begin
            s1_vld_reg <= 1'b0;
            s1_open_reg <= 1'b0;
            s1_ch_reg <= 3'h0;
            s1_val_reg <= 16'h0000;
        end else begin
            s1_vld_reg <= ADC_DONE && running;
            if (ADC_DONE) begin
                s1_open_reg <= cv_open;
                s1_ch_reg <= ADC_CH;
                s1_val_reg <= cv_val;
            end
        end
    end

    // Oldest sample leaves the running sum as the new one enters
    wire logic [3:0] s2_cnt = cnt_reg[s1_ch_reg];
    wire logic s2_wrap = s2_cnt == `AIPP_AVG_N;
    wire logic signed [18:0] s2_old = s2_wrap ? 19'($signed(hist_rdata))
        : 19'sh0;
    wire logic signed [18:0] s2_sum = sum_reg[s1_ch_reg]
        + 19'(s1_val_reg) - s2_old;
    wire logic [3:0] s2_cnt_n = s2_wrap ? s2_cnt : s2_cnt + 4'h1;
    wire logic signed [18:0] s2_avg = s2_sum >>> `AIPP_AVG_SH;
    wire logic s2_upd = s1_vld_reg && (!avg_en_reg || s1_open_reg
        || s2_cnt_n == `AIPP_AVG_N);
    wire logic [15:0] s2_data = s1_open_reg ? `AIPP_OPEN_CODE :
        avg_en_reg ? s2_avg[15:0] : s1_val_reg;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            open_reg <= 8'h00;
            ready_reg <= 8'h00;
            for (int i = 0; i < 8; i++) begin
                ptr_reg[i] <= 3'h0;
                cnt_reg[i] <= 4'h0;
                sum_reg[i] <= 19'sh0;
                data_reg[i] <= 16'h0000;
            end
        end else if (s1_vld_reg) begin
            open_reg[s1_ch_reg] <= s1_open_reg;
            ptr_reg[s1_ch_reg] <= ptr_reg[s1_ch_reg] + 3'h1;
            cnt_reg[s1_ch_reg] <= s2_cnt_n;
            sum_reg[s1_ch_reg] <= s2_sum;
            if (s2_upd) begin
                data_reg[s1_ch_reg] <= s2_data;
                ready_reg[s1_ch_reg] <= 1'b1;
            end
        end
    end

    // Calibration capture uses the next conversion of the chosen channel
    wire logic cal_cmd = REG_WR && REG_ADDR == `AIPP_A_CAL
        && (REG_WDATA[`AIPP_CAL_OFS] || REG_WDATA[`AIPP_CAL_GAIN]);
    wire logic cal_bad = four_reg && REG_WDATA[0];
    wire logic cal_hit = ADC_DONE && ADC_CH == cal_ch_reg;
    wire logic signed [17:0] cal_rel = 18'($signed(ADC_RAW)) - cv_zero;
    wire logic ofs_ok = cal_rel >= -18'(WIN) && cal_rel <= 18'(WIN);
    wire logic gain_ok = cv_diff >= 18'(SPAN) - 18'(WIN)
        && cv_diff <= 18'(SPAN) + 18'(WIN);
    wire logic rng_wr = REG_WR && REG_ADDR[4:3] == `AIPP_BLK_RANGE;
    wire logic [45:0] div_sh = {div_acc_reg[44:0], 1'b0};
    wire logic div_ge = div_sh[45:28] >= {1'b0, div_d_reg};
    wire logic [17:0] div_rem = div_sh[45:28] - {1'b0, div_d_reg};
    wire logic [45:0] div_step = div_ge ? {div_rem, div_sh[27:1], 1'b1}
        : div_sh;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            cal_state_reg <= aipp_pkg::CAL_IDLE;
            cal_ch_reg <= 3'h0;
            cal_gain_reg <= 1'b0;
            cal_err_reg <= 1'b0;
            cal_res_reg <= 16'h0000;
            div_acc_reg <= 46'h0;
            div_d_reg <= 17'h0;
            div_cnt_reg <= 5'h00;
        end else begin
            case (cal_state_reg)
                aipp_pkg::CAL_IDLE: if (cal_cmd && running) begin
                    cal_err_reg <= cal_bad;
                    cal_ch_reg <= REG_WDATA[2:0];
                    cal_gain_reg <= REG_WDATA[`AIPP_CAL_GAIN];
                    if (!cal_bad) begin
                        cal_state_reg <= aipp_pkg::CAL_WAIT;
                    end
                end
                aipp_pkg::CAL_WAIT: if (cal_hit) begin
                    if (cal_gain_reg && gain_ok) begin
                        div_acc_reg <= {18'h0, 28'(`AIPP_SPAN) << `AIPP_GAIN_SH};
                        div_d_reg <= cv_diff[16:0];
                        div_cnt_reg <= 5'h00;
                        cal_state_reg <= aipp_pkg::CAL_DIV;
                    end else if (!cal_gain_reg && ofs_ok) begin
                        cal_res_reg <= cal_rel[15:0];
                        cal_state_reg <= aipp_pkg::CAL_STORE;
                    end else begin
                        cal_err_reg <= 1'b1;
                        cal_state_reg <= aipp_pkg::CAL_IDLE;
                    end
                end
                aipp_pkg::CAL_DIV: begin
                    div_acc_reg <= div_step;
                    div_cnt_reg <= div_cnt_reg + 5'h01;
                    if (div_cnt_reg == `AIPP_DIV_STEPS - 5'h01) begin
                        cal_res_reg <= div_step[15:0] - `AIPP_GAIN_ONE;
                        cal_state_reg <= aipp_pkg::CAL_STORE;
                    end
                end
                aipp_pkg::CAL_STORE: if (!rng_wr) begin
                    cal_state_reg <= aipp_pkg::CAL_IDLE;
                end
                default: cal_state_reg <= aipp_pkg::CAL_IDLE;
            endcase
        end
    end

    // Range writes own the store port; a finished capture waits in CAL_STORE while a range write is strobed
    wire logic cal_wr = cal_state_reg == aipp_pkg::CAL_STORE && !rng_wr;
    wire logic nv_we = running && (rng_wr || cal_wr);
    wire logic [4:0] nv_waddr = rng_wr ? {`AIPP_NV_RANGE, REG_ADDR[2:0]}
        : {cal_gain_reg ? `AIPP_NV_GAIN : `AIPP_NV_OFS, cal_ch_reg};
    wire logic [15:0] nv_wdata = rng_wr ? {13'h0, REG_WDATA[2:0]}
        : cal_res_reg;

    aipp_mem #(.W(16), .AW(5)) u_nvm (
        .clk(MCLK),
        .we(nv_we),
        .waddr(nv_waddr),
        .wdata(nv_wdata),
        .raddr(ld_cnt_reg),
        .rdata(nv_rdata)
    );

    aipp_mem #(.W(16), .AW(6)) u_hist (
        .clk(MCLK),
        .we(s1_vld_reg),
        .waddr({s1_ch_reg, ptr_reg[s1_ch_reg]}),
        .wdata(s1_val_reg),
        .raddr({ADC_CH, ptr_reg[ADC_CH]}),
        .rdata(hist_rdata)
    );

    wire logic cal_busy = cal_state_reg != aipp_pkg::CAL_IDLE;
    wire logic [15:0] cfg_word = (16'(avg_en_reg) << `AIPP_CFG_AVG)
        | (16'(four_reg) << `AIPP_CFG_FOUR) | (16'(soft_reg) << `AIPP_CFG_SOFT)
        | (16'(running) << `AIPP_CFG_RUN) | (16'(cal_busy) << `AIPP_CFG_CBUSY)
        | (16'(cal_err_reg) << `AIPP_CFG_CERR);
    wire logic [15:0] rd_val = REG_ADDR[4:3] == `AIPP_BLK_DATA ?
        data_reg[REG_ADDR[2:0]] : REG_ADDR == `AIPP_A_STAT ?
        {ready_reg, open_reg} : REG_ADDR == `AIPP_A_CFG ? cfg_word :
        REG_ADDR[4:3] == `AIPP_BLK_RANGE ?
        {13'h0, range_pend_reg[REG_ADDR[2:0]]} : 16'h0000;

    always_ff @(posedge MCLK) begin
        REG_RDATA <= (RST || !REG_RD) ? 16'h0000 : rd_val;
    end

    // Checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    logic [31:0] gap_cnt_reg;
    logic seen_reg;
    always_ff @(posedge MCLK) begin
        if (RST) begin
            gap_cnt_reg <= 32'h0;
            seen_reg <= 1'b0;
        end else begin
            gap_cnt_reg <= ADC_START ? 32'h0 : gap_cnt_reg + 32'h1;
            seen_reg <= seen_reg || ADC_START;
        end
    end

    property p_cadence;
        ADC_START && seen_reg |-> gap_cnt_reg == 32'(TICK_CYC - 1);
    endproperty
    a_cadence: assert property (p_cadence)
        else $error("conversion cadence wrong");
    property p_even_only;
        ADC_START && four_reg |-> !ADC_CH[0];
    endproperty
    a_even_only: assert property (p_even_only)
        else $error("odd channel converted in four channel mode");
    property p_open_code;
        s1_vld_reg && s1_open_reg |=> data_reg[$past(s1_ch_reg)]
            == `AIPP_OPEN_CODE && open_reg[$past(s1_ch_reg)];
    endproperty
    a_open_code: assert property (p_open_code)
        else $error("open channel not reported as open code");
    property p_open_stable;
        !s1_vld_reg |=> $stable(open_reg);
    endproperty
    a_open_stable: assert property (p_open_stable)
        else $error("open flag changed outside a conversion");
    property p_withhold;
        s1_vld_reg && avg_en_reg && !s1_open_reg && !ready_reg[s1_ch_reg]
            && cnt_reg[s1_ch_reg] < 4'h7 |=> !ready_reg[$past(s1_ch_reg)];
    endproperty
    a_withhold: assert property (p_withhold)
        else $error("averaged value reported before eight samples");
    property p_clamp;
        s1_vld_reg && !s1_open_reg |-> s1_val_reg >= BIP_LO
            && s1_val_reg <= UNI_HI;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("converted value outside data range");
    property p_frozen;
        running |=> $stable(range_act_reg[0]) && $stable(avg_en_reg);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("settings changed without a reset");
    property p_no_early;
        !running |-> !ADC_START ##1 !s1_vld_reg;
    endproperty
    a_no_early: assert property (p_no_early)
        else $error("conversion before stored settings loaded");
    property p_pairs;
        running && !soft_reg |-> range_act_reg[0] == range_act_reg[1]
            && range_act_reg[6] == range_act_reg[7];
    endproperty
    a_pairs: assert property (p_pairs)
        else $error("switch ranges not shared by channel pairs");
    property p_ofs_win;
        nv_we && !rng_wr && !cal_gain_reg |-> $signed(nv_wdata) >= -WIN
            && $signed(nv_wdata) <= WIN;
    endproperty
    a_ofs_win: assert property (p_ofs_win)
        else $error("stored offset outside window");

    c_open: cover property (s1_vld_reg && s1_open_reg);
    c_avg_ready: cover property (avg_en_reg && $rose(ready_reg[0]));
    c_cal_store: cover property (cal_wr);
    c_four: cover property (ADC_START && four_reg && ADC_CH == 3'h6);
endmodule // aipp_core

/* File: aipp_adc_model.sv */
`timescale 1ns/1ps
module aipp_adc_model #(
    parameter int DLY = 3
) (
    input wire logic clk, // Clock
    input wire logic start, // Conversion start pulse
    input wire logic [2:0] ch, // Channel requested
    input wire logic [7:0][15:0] raw_tab, // Input value per channel
    output logic done, // Result valid pulse
    output logic [15:0] raw // Result word
);
    int cnt = 0;
    logic [2:0] ch_q = 3'h0;
    initial begin
        done = 1'b0;
        raw = 16'h0000;
    end
    // Result answers only a start, one pulse, then the bus keeps toggling
    // so a stale word is never mistaken for a fresh one
    always @(posedge clk) begin
        done <= 1'b0;
        raw <= ~raw;
        if (start) begin
            ch_q <= ch;
            cnt <= DLY;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            done <= 1'b1;
            raw <= raw_tab[ch_q];
        end
    end
endmodule // aipp_adc_model

/* File: analog_input_postprocess_tb.sv */
`timescale 1ns/1ps
module analog_input_postprocess_tb;
    localparam int TICK = 30;
    logic MCLK = 1'b0, RST = 1'b1, ADC_DONE, ADC_START, REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [15:0] SW = 16'h0000, ADC_RAW, REG_RDATA, REG_WDATA = 16'h0000;
    logic [4:0] REG_ADDR = 5'h00;
    logic [2:0] ADC_CH, ADC_RANGE;
    logic [7:0][15:0] raw_tab = '0;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    initial forever #50 MCLK = ~MCLK;
    aipp_core #(.TICK_CYC(TICK)) u_dut (.MCLK(MCLK), .RST(RST), .SW(SW),
        .ADC_START(ADC_START), .ADC_CH(ADC_CH), .ADC_RANGE(ADC_RANGE),
        .ADC_DONE(ADC_DONE), .ADC_RAW(ADC_RAW), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA));
    aipp_adc_model #(.DLY(3)) u_adc (.clk(MCLK), .start(ADC_START),
        .ch(ADC_CH), .raw_tab(raw_tab), .done(ADC_DONE), .raw(ADC_RAW));
    task automatic check(input string nm, input logic [15:0] got,
                         input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge MCLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge MCLK);
        REG_RD <= 1'b0;
        @(negedge MCLK);
        check($sformatf("reg %h", a), REG_RDATA, exp);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge MCLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge MCLK);
        REG_WR <= 1'b0;
    endtask
    task automatic do_reset(input logic [15:0] sw);
        @(posedge MCLK);
        SW <= sw;
        RST <= 1'b1;
        repeat (8) @(posedge MCLK);
        RST <= 1'b0;
        repeat (30) @(posedge MCLK);
    endtask
    // Returns once the result of the next conversion of ch is readable
    task automatic wait_conv(input logic [2:0] ch);
        for (int i = 0; i < 20 * TICK; i++) begin
            @(negedge MCLK);
            if (ADC_START === 1'b1 && ADC_CH === ch) break;
        end
        repeat (8) @(negedge MCLK);
    endtask
    // Cycles between two starts of channel 0; flags odd channels on the way
    task automatic period(input int exp, input logic four);
        int n;
        logic odd;
        n = 0;
        odd = 1'b0;
        wait_conv(3'h0);
        while (!(ADC_START === 1'b1 && ADC_CH === 3'h0) && n < 20 * TICK) begin
            @(negedge MCLK);
            n++;
            if (ADC_START === 1'b1 && ADC_CH[0] !== 1'b0) odd = 1'b1;
        end
        check("start period", 16'(n + 8), 16'(exp));
        check("odd channel started", {15'h0, odd}, {15'h0, !four});
    endtask
    task automatic t_eight();
        logic [7:0][15:0] ex;
        raw_tab = {16'hFE0C, 16'd100, 16'd5000, 16'hFC18,
                   16'd6500, 16'hFE0C, 16'd3000, 16'hFE70};
        ex = {16'hFED4, 16'h0064, 16'h0CE4, 16'hFC18,
              16'h189C, 16'h7FFF, 16'h0BB8, 16'h7FFF};
        rd(5'h09, 16'h0008);
        rd(5'h1F, 16'h0000);
        wait_conv(3'h7);
        wait_conv(3'h7);
        for (int c = 0; c < 8; c++) rd(5'(c), ex[c]);
        rd(5'h08, 16'hFF05);
        period(8 * TICK, 1'b0);
        $display("eight channel conversion done");
    endtask
    task automatic t_clear();
        wr(5'h12, 16'h0003);
        rd(5'h12, 16'h0003);
        raw_tab[0] = 16'd1000;
        wait_conv(3'h0);
        rd(5'h00, 16'd1000);
        wait_conv(3'h2);
        rd(5'h02, 16'h7FFF);
        rd(5'h08, 16'hFF04);
        $display("open clear done");
    endtask
    task automatic t_avg();
        raw_tab = {8{16'd800}};
        do_reset(16'h34E1);
        rd(5'h09, 16'h000B);
        repeat (7) wait_conv(3'h6);
        rd(5'h08, 16'h0000);
        wait_conv(3'h6);
        rd(5'h08, 16'h5500);
        rd(5'h06, 16'd800);
        raw_tab[6] = 16'd1600;
        wait_conv(3'h6);
        rd(5'h06, 16'd900);
        rd(5'h04, 16'd800);
        period(4 * TICK, 1'b1);
        $display("averaging four channel done");
    endtask
    // Captures land in the store and only act after the next reset
    task automatic t_cal();
        raw_tab = {8{16'd800}};
        raw_tab[1] = 16'd100;
        raw_tab[3] = 16'd6144;
        raw_tab[5] = 16'd1000;
        do_reset(16'h8000);
        wr(5'h0A, 16'h0105);
        wait_conv(3'h5);
        rd(5'h09, 16'h002C);
        wr(5'h0A, 16'h0101);
        rd(5'h09, 16'h001C);
        wait_conv(3'h1);
        wr(5'h0A, 16'h0203);
        wait_conv(3'h3);
        wait_conv(3'h4);
        rd(5'h09, 16'h000C);
        do_reset(16'h8000);
        wait_conv(3'h2);
        check("range ch2", {13'h0, ADC_RANGE}, 16'h0003);
        wait_conv(3'h5);
        rd(5'h01, 16'h0000);
        rd(5'h03, 16'h1770);
        rd(5'h05, 16'd1000);
        $display("calibration capture done");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        do_reset(16'h04E1);
        t_eight();
        t_clear();
        t_avg();
        t_cal();
        tally_and_finish();
    end
endmodule // analog_input_postprocess_tb
